// file: sysctl_consts.vh
`ifndef SYSCTL_CONSTS_VH
`define SYSCTL_CONSTS_VH
// register location and reset image
`define SC_OFFSET 8'h80
`define SC_RESET 32'h0044_9060
// field positions
`define SC_ROUTE 26
`define SC_FLAG 25
`define SC_ENABLE 24
`define SC_PMREV 23
`define SC_SPARE 22
`define SC_GUARD 21
`define SC_VFLOAT 20
`define SC_DREQ 19
`define SC_CHAN_HI 18
`define SC_CHAN_LO 16
`define SC_BURST_DN 15
`define SC_BURST_UP 14
`define SC_ACTIVE 13
`define SC_ONE 12
`define SC_BUSY 11
`define SC_UPWAIT 10
`define SC_DNWAIT 9
// clock and power switch timing
`define CLK_PERIOD_NS 40
`define SW_BIT_NS 1000
`define SW_BIT_CYC ((`SW_BIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SW_BITS 24
`define PWR_UP_DELAY_US 300
`define PWR_UP_DELAY_CYC ((`PWR_UP_DELAY_US * 1000) / `CLK_PERIOD_NS)
`define PWR_DN_DELAY_US 100
`define PWR_DN_DELAY_CYC ((`PWR_DN_DELAY_US * 1000) / `CLK_PERIOD_NS)
`endif

// file: socket_system_control_bits.v
`timescale 1ns/1ps
`include "sysctl_consts.vh"

module socket_system_control_bits #(
  parameter SW_BITS = `SW_BITS,
  parameter UP_DELAY_CYC = `PWR_UP_DELAY_CYC,
  parameter DN_DELAY_CYC = `PWR_DN_DELAY_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // configuration access
  input wire cfg_wr,
  input wire cfg_rd,
  input wire cfg_func,
  input wire [7:0] cfg_addr,
  input wire [3:0] cfg_be,
  input wire [31:0] cfg_wdata,
  output reg [31:0] cfg_rdata,
  // socket events, one bit per socket/function
  input wire [1:0] power_write,
  input wire [1:0] power_up_req,
  input wire [1:0] card_access,
  input wire [1:0] cardbus_present,
  input wire [1:0] card16_present,
  input wire [1:0] card_dreq,
  // interrupt pulses
  output reg irq2_pulse,
  output reg [1:0] card_status_change,
  // socket controls
  output wire [1:0] spare_pin_low_oe,
  output wire [1:0] supply_guard_on,
  output wire [1:0] addr_hi_float,
  output wire [1:0] dma_request,
  output wire [5:0] dma_channel_assign,
  output wire [1:0] pm_rev11,
  output wire read_burst_downstream_en,
  output wire read_burst_upstream_en,
  // power switch stream
  output reg sw_clk_en,
  output wire power_serial_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire hit = (cfg_addr == `SC_OFFSET);
  wire wr_hit = cfg_wr & hit;
  wire wr_f0 = wr_hit & ~cfg_func;
  wire [31:0] wmask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
  wire [31:0] rst_img = `SC_RESET;

  ////////////////////////////////////////////////////////////////////////////
  // shared and global fields
  reg route_q;
  reg enable_q;
  reg burst_dn_q;
  reg burst_up_q;
  always @(posedge clk) begin
    if (rst) begin
      route_q <= 1'b0;
      enable_q <= 1'b0;
      burst_dn_q <= 1'b1;
      burst_up_q <= 1'b0;
    end else begin
      if (wr_hit & wmask[`SC_ROUTE])
        route_q <= cfg_wdata[`SC_ROUTE];
      if (wr_f0 & wmask[`SC_ENABLE])
        enable_q <= cfg_wdata[`SC_ENABLE];
      if (wr_f0 & wmask[`SC_BURST_DN])
        burst_dn_q <= cfg_wdata[`SC_BURST_DN];
      if (wr_f0 & wmask[`SC_BURST_UP])
        burst_up_q <= cfg_wdata[`SC_BURST_UP];
    end
  end
  assign read_burst_downstream_en = burst_dn_q;
  assign read_burst_upstream_en = burst_up_q;

  ////////////////////////////////////////////////////////////////////////////
  // per-function fields
  reg [1:0] flag_q;
  reg [1:0] pmrev_q;
  reg [1:0] spare_q;
  reg [1:0] guard_q;
  reg [1:0] vfloat_q;
  reg [1:0] dreq_q;
  reg [5:0] chan_q;
  reg [1:0] active_q;
  reg [1:0] csc_d;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_fn
      wire wr_me = wr_hit & (cfg_func == i);
      wire rd_me = cfg_rd & hit & (cfg_func == i);
      wire set_flag = power_write[i] & enable_q;
      always @(posedge clk) begin
        if (rst) begin
          flag_q[i] <= 1'b0;
          pmrev_q[i] <= 1'b0;
          spare_q[i] <= rst_img[`SC_SPARE];
          guard_q[i] <= 1'b0;
          vfloat_q[i] <= 1'b0;
          dreq_q[i] <= 1'b0;
          chan_q[3*i+2 -: 3] <= rst_img[`SC_CHAN_HI:`SC_CHAN_LO];
          active_q[i] <= 1'b0;
        end else begin
          // set wins over a same-cycle clear
          if (set_flag)
            flag_q[i] <= 1'b1;
          else if (wr_me & wmask[`SC_FLAG] & cfg_wdata[`SC_FLAG])
            flag_q[i] <= 1'b0;
          if (card_access[i])
            active_q[i] <= 1'b1;
          else if (rd_me)
            active_q[i] <= 1'b0;
          if (wr_me & wmask[`SC_PMREV])
            pmrev_q[i] <= cfg_wdata[`SC_PMREV];
          if (wr_me & wmask[`SC_SPARE])
            spare_q[i] <= cfg_wdata[`SC_SPARE];
          if (wr_me & wmask[`SC_GUARD])
            guard_q[i] <= cfg_wdata[`SC_GUARD];
          if (wr_me & wmask[`SC_VFLOAT])
            vfloat_q[i] <= cfg_wdata[`SC_VFLOAT];
          if (wr_me & wmask[`SC_DREQ])
            dreq_q[i] <= cfg_wdata[`SC_DREQ];
          if (wr_me & wmask[`SC_CHAN_LO])
            chan_q[3*i+2 -: 3] <= cfg_wdata[`SC_CHAN_HI:`SC_CHAN_LO];
        end
      end
      always @* begin
        csc_d[i] = set_flag & route_q;
      end
      assign spare_pin_low_oe[i] = cardbus_present[i] & spare_q[i];
      assign supply_guard_on[i] = card16_present[i] & ~guard_q[i];
      assign addr_hi_float[i] = card16_present[i] & vfloat_q[i];
      assign dma_request[i] = card16_present[i] & dreq_q[i] & card_dreq[i];
    end
  endgenerate
  assign pm_rev11 = pmrev_q;
  assign dma_channel_assign = chan_q;

  // interrupt pulses: routing picks irq2 or the socket's status change
  always @(posedge clk) begin
    if (rst) begin
      irq2_pulse <= 1'b0;
      card_status_change <= 2'h0;
    end else begin
      irq2_pulse <= |(power_write & {2{enable_q}}) & ~route_q;
      card_status_change <= csc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power switch stream and settle delay
  localparam ST_IDLE = 2'h0;
  localparam ST_SHIFT = 2'h1;
  localparam ST_WAIT = 2'h2;
  localparam [15:0] BIT_CYC = `SW_BIT_CYC;
  reg [1:0] st_q;
  reg [15:0] div_q;
  reg [7:0] bits_q;
  reg [31:0] wait_q;
  reg up_q;
  reg upwait_q;
  reg dnwait_q;
  // one stream at a time; a power write during a stream is not queued
  wire pw_any = |power_write;
  always @(posedge clk) begin
    if (rst) begin
      st_q <= ST_IDLE;
      div_q <= 16'h0000;
      bits_q <= 8'h00;
      wait_q <= 32'h0000_0000;
      up_q <= 1'b0;
      upwait_q <= 1'b0;
      dnwait_q <= 1'b0;
      sw_clk_en <= 1'b0;
    end else begin
      sw_clk_en <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (pw_any) begin
            st_q <= ST_SHIFT;
            up_q <= |(power_write & power_up_req);
            div_q <= 16'h0000;
            bits_q <= 8'h00;
          end
        end
        ST_SHIFT: begin
          if (div_q == BIT_CYC - 16'h0001) begin
            div_q <= 16'h0000;
            sw_clk_en <= 1'b1;
            bits_q <= bits_q + 8'h01;
            if (bits_q == SW_BITS - 1) begin
              st_q <= ST_WAIT;
              upwait_q <= up_q;
              dnwait_q <= ~up_q;
              wait_q <= up_q ? UP_DELAY_CYC : DN_DELAY_CYC;
            end
          end else begin
            div_q <= div_q + 16'h0001;
          end
        end
        ST_WAIT: begin
          if (wait_q <= 32'h0000_0001) begin
            st_q <= ST_IDLE;
            upwait_q <= 1'b0;
            dnwait_q <= 1'b0;
          end else begin
            wait_q <= wait_q - 32'h0000_0001;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  assign power_serial_busy = (st_q != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // read data; status bits have no write path
  always @(posedge clk) begin
    if (rst) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (cfg_rd) begin
      cfg_rdata <= 32'h0000_0000;
      if (hit) begin
        cfg_rdata[`SC_ROUTE] <= route_q;
        cfg_rdata[`SC_FLAG] <= flag_q[cfg_func];
        cfg_rdata[`SC_ENABLE] <= enable_q;
        cfg_rdata[`SC_PMREV] <= pmrev_q[cfg_func];
        cfg_rdata[`SC_SPARE] <= spare_q[cfg_func];
        cfg_rdata[`SC_GUARD] <= guard_q[cfg_func];
        cfg_rdata[`SC_VFLOAT] <= vfloat_q[cfg_func];
        cfg_rdata[`SC_DREQ] <= dreq_q[cfg_func];
        cfg_rdata[`SC_CHAN_HI:`SC_CHAN_LO] <= cfg_func ? chan_q[5:3] : chan_q[2:0];
        cfg_rdata[`SC_BURST_DN] <= burst_dn_q;
        cfg_rdata[`SC_BURST_UP] <= burst_up_q;
        cfg_rdata[`SC_ACTIVE] <= active_q[cfg_func];
        cfg_rdata[`SC_ONE] <= 1'b1;
        cfg_rdata[`SC_BUSY] <= power_serial_busy;
        cfg_rdata[`SC_UPWAIT] <= upwait_q;
        cfg_rdata[`SC_DNWAIT] <= dnwait_q;
      end
    end
  end

endmodule // socket_system_control_bits

// file: socket_system_control_bits_monitor.sv
`timescale 1ns/1ps
module sysctl_monitor (
  // clock and reset
  input wire clk,
  input wire rst,
  // host and socket side
  input wire cfg_rd,
  input wire [7:0] cfg_addr,
  input wire [31:0] cfg_rdata,
  input wire [1:0] power_write,
  input wire [1:0] cardbus_present,
  input wire [1:0] card_dreq,
  // device outputs
  input wire irq2_pulse,
  input wire [1:0] card_status_change,
  input wire [1:0] spare_pin_low_oe,
  input wire [1:0] dma_request,
  input wire sw_clk_en,
  input wire power_serial_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_idle_write;
    !power_serial_busy && power_write != 2'b00;
  endsequence
  sequence s_hold_busy;
    power_serial_busy [*8];
  endsequence
  chk_stream_start: assert property (s_idle_write |=> s_hold_busy)
    else $error("power stream did not start or dropped early");
  chk_clk_in_stream: assert property (sw_clk_en |-> power_serial_busy)
    else $error("switch clock pulse outside stream");
  chk_irq2_cause: assert property (irq2_pulse |-> $past(power_write) != 2'b00)
    else $error("irq2 pulse without power write");
  chk_csc_cause: assert property ((card_status_change & ~$past(power_write)) == 2'b00)
    else $error("status change pulse without socket power write");
  chk_route_excl: assert property (!(irq2_pulse && card_status_change != 2'b00))
    else $error("interrupt raised on both routes");
  chk_spare_card: assert property ((spare_pin_low_oe & ~cardbus_present) == 2'b00)
    else $error("spare terminals driven with no cardbus card");
  chk_dma_gate: assert property ((dma_request & ~card_dreq) == 2'b00)
    else $error("dma request forwarded with no card request");
  chk_reserved_one: assert property (cfg_rd && cfg_addr == 8'h80 |=> cfg_rdata[12])
    else $error("reserved bit read back zero");
endmodule // sysctl_monitor
bind socket_system_control_bits sysctl_monitor sysctl_monitor_i (.clk, .rst, .cfg_rd,
  .cfg_addr, .cfg_rdata, .power_write, .cardbus_present, .card_dreq, .irq2_pulse,
  .card_status_change, .spare_pin_low_oe, .dma_request, .sw_clk_en, .power_serial_busy);

// file: socket_far_side.sv
`timescale 1ns/1ps
module socket_far_side (
  // clock and switch stream
  input wire clk,
  input wire sw_clk_en,
  // card side
  output reg [1:0] cardbus_present,
  output reg [1:0] card16_present,
  output reg [1:0] card_dreq,
  output reg [1:0] card_access,
  output reg [7:0] n_bits
);
  initial begin
    cardbus_present = 2'b01;
    card16_present = 2'b10;
    card_dreq = 2'b11;
    card_access = 2'b00;
    n_bits = 8'h00;
  end
  // switch latches one bit per enable pulse
  always @(posedge clk) if (sw_clk_en) n_bits <= n_bits + 8'h01;
  task touch(input int i);
    @(posedge clk) #1 card_access[i] = 1'b1;
    @(posedge clk) #1 card_access[i] = 1'b0;
  endtask
endmodule // socket_far_side

// file: socket_system_control_bits_test.sv
`timescale 1ns/1ps
module socket_system_control_bits_test;
  reg clk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0, cfg_func = 1'b0;
  reg [7:0] cfg_addr = 8'h80;
  reg [3:0] cfg_be = 4'h0;
  reg [31:0] cfg_wdata = 32'h0;
  reg [1:0] power_write = 2'b00, power_up_req = 2'b00;
  wire [31:0] cfg_rdata;
  wire irq2_pulse, sw_clk_en, power_serial_busy;
  wire read_burst_downstream_en, read_burst_upstream_en;
  wire [1:0] card_status_change, spare_pin_low_oe, pm_rev11;
  wire [1:0] cardbus_present, card16_present, card_dreq, card_access;
  wire [1:0] supply_guard_on, addr_hi_float, dma_request;
  wire [5:0] dma_channel_assign;
  wire [7:0] n_bits;
  int num_errors = 0, n_compared = 0, n_irq = 0;
  logic [31:0] exp_q[$];
  reg rd_seen = 1'b0;
  reg [7:0] r;
  always #20 clk = ~clk;
  socket_system_control_bits #(.SW_BITS(2), .UP_DELAY_CYC(8), .DN_DELAY_CYC(6))
    socket_system_control_bits_i (.*);
  socket_far_side socket_far_side_i (.*);
  //////////////////////////////////////////////////////////////////////////////
  task check(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task rd(input logic f, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) #1 cfg_rd = 1'b1;
    cfg_func = f;
    cfg_addr = a;
    exp_q.push_back(e);
    @(posedge clk) #1 cfg_rd = 1'b0;
  endtask
  task wr(input logic f, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk) #1 cfg_wr = 1'b1;
    cfg_func = f;
    cfg_addr = 8'h80;
    cfg_be = be;
    cfg_wdata = d;
    @(posedge clk) #1 cfg_wr = 1'b0;
  endtask
  task pw(input int i, input logic up);
    @(posedge clk) #1 power_write[i] = 1'b1;
    power_up_req[i] = up;
    @(posedge clk) #1 power_write[i] = 1'b0;
  endtask
  // nb nonzero waits for switch bits, zero waits for idle
  task wait_for(input int nb);
    int k;
    for (k = 0; k < 400 && (nb ? n_bits < nb : power_serial_busy !== 1'b0); k++) @(posedge clk);
    if (k == 400) begin
      num_errors++;
      wrap_up();
    end
  endtask
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // read data lands one cycle after the strobe; irq2 counts 1, socket1 change 16
  always @(posedge clk) begin
    rd_seen <= cfg_rd;
    n_irq <= n_irq + irq2_pulse + 16 * card_status_change[1];
    if (rd_seen) check("cfg_rdata", exp_q.pop_front(), cfg_rdata);
  end
  initial begin
    void'($urandom(57280));
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    rd(0, 8'h80, 32'h0044_9000);
    rd(1, 8'h80, 32'h0044_9000);
    rd(0, 8'h84, 32'h0);
    check("bursts", 32'h2, {read_burst_downstream_en, read_burst_upstream_en});
    $display("reset test done");
    wr(0, 4'hf, 32'hffff_ffff);
    rd(0, 8'h80, 32'h05ff_d000);
    rd(1, 8'h80, 32'h0544_d000);
    wr(1, 4'hf, 32'h0);
    rd(1, 8'h80, 32'h0100_d000);
    r = $urandom;
    wr(0, 4'h4, {8'h0, r, 16'h0});
    rd(0, 8'h80, {8'h01, r, 16'hd000});
    wr(1, 4'h4, {8'h0, r, 16'h0});
    rd(1, 8'h80, {8'h01, r, 16'hd000});
    check("channel", r[2:0], dma_channel_assign[2:0]);
    check("channel1", r[2:0], dma_channel_assign[5:3]);
    check("spare", {1'b0, r[6]}, spare_pin_low_oe);
    check("pm rev", {r[7], r[7]}, pm_rev11);
    check("guard", {~r[5], 1'b0}, supply_guard_on);
    check("addr float", {r[4], 1'b0}, addr_hi_float);
    check("dma request", {r[3], 1'b0}, dma_request);
    $display("access test done");
    wr(0, 4'h8, 32'h0100_0000);
    pw(0, 1'b1);
    rd(0, 8'h80, {8'h03, r, 16'hd800});
    wait_for(2);
    rd(0, 8'h80, {8'h03, r, 16'hdc00});
    wait_for(0);
    wr(0, 4'h8, 32'h0100_0000);
    rd(0, 8'h80, {8'h03, r, 16'hd000});
    wr(0, 4'h8, 32'h0300_0000);
    rd(0, 8'h80, {8'h01, r, 16'hd000});
    wr(0, 4'h8, 32'h0500_0000);
    pw(1, 1'b0);
    pw(1, 1'b0);
    wait_for(4);
    rd(1, 8'h80, {8'h07, r, 16'hda00});
    wait_for(0);
    check("switch bits", 32'h4, n_bits);
    check("irq events", 32'd33, n_irq);
    $display("power test done");
    socket_far_side_i.touch(1);
    rd(1, 8'h80, {8'h07, r, 16'hf000});
    rd(1, 8'h80, {8'h07, r, 16'hd000});
    @(posedge clk);
    $display("activity test done");
    wrap_up();
  end
endmodule // socket_system_control_bits_test
